/* File: shared/ps2s_params.svh */
`ifndef PS2S_PARAMS_SVH
`define PS2S_PARAMS_SVH

// ************************************************************
// channel count and register offsets
// ************************************************************
`define PS2S_NCH          4
`define PS2S_ADDR_STAT_A  16'h7F43
`define PS2S_ADDR_STAT_B  16'h7F47
`define PS2S_ADDR_STAT_C  16'h7F4B
`define PS2S_ADDR_STAT_D  16'h7F4F
`define PS2S_ADDR_STAT2   16'h7F48

// ************************************************************
// status bit positions and reset values
// ************************************************************
`define PS2S_B_RDY        0
`define PS2S_B_RXE        1
`define PS2S_B_PE         2
`define PS2S_B_FE         3
`define PS2S_B_TXI        4
`define PS2S_B_TXTO       5
`define PS2S_B_DAT        6
`define PS2S_B_CLK        7
`define PS2S_STAT_RST     8'h00
`define PS2S_STAT2_RST    8'h00
`define PS2S_RDATA_RST    8'h00

// ************************************************************
// parity and stop mode encodings
// ************************************************************
`define PS2S_PAR_ODD      2'h0
`define PS2S_PAR_EVEN     2'h1
`define PS2S_PAR_NONE     2'h2
`define PS2S_STOP_HIGH    2'h0
`define PS2S_STOP_LOW     2'h1
`define PS2S_STOP_NONE    2'h2

// ************************************************************
// frame edge numbers and timing
// ************************************************************
`define PS2S_EDGE_PAR     4'hA
`define PS2S_EDGE_STOP    4'hB
`define PS2S_CLK_HZ       10000000
`define PS2S_GAP_US       300
`define PS2S_FRAME_US     2000
`define PS2S_START_US     25000
`define PS2S_CYC_PER_US   (`PS2S_CLK_HZ / 1000000)
`define PS2S_GAP_CYC      (`PS2S_GAP_US * `PS2S_CYC_PER_US)
`define PS2S_FRAME_CYC    (`PS2S_FRAME_US * `PS2S_CYC_PER_US)
`define PS2S_START_CYC    (`PS2S_START_US * `PS2S_CYC_PER_US)

`endif

/* File: shared/ps2s_pkg.sv */
// ************************************************************
// shared types
// ************************************************************
package ps2s_pkg;

  // per-channel frame state, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_TXW  = 5'h04,
    ST_TX   = 5'h08,
    ST_HOLD = 5'h10
  } ps2s_state_t;

  // per-channel control bits, as held outside
  typedef struct packed {
    logic       wr_clk;
    logic       wr_data;
    logic [1:0] stop_mode;
    logic [1:0] parity_mode;
    logic       auto_engine_enable;
    logic       direction_select;
  } ps2s_ctrl_t;

  // received byte tagged with its channel
  typedef struct packed {
    logic [1:0] chan;
    logic [7:0] data;
  } ps2s_rxword_t;

endpackage

/* File: hdl/ps2s_buf2.sv */
// ************************************************************
// small fifo with valid/ready on both sides
// ************************************************************
module ps2s_buf2 #(
  parameter int W     = 10,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         reset_n_i,
  // fill side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // drain side
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_ff [DEPTH];  // storage words
  logic [AW-1:0] wp_ff;           // write pointer
  logic [AW-1:0] rp_ff;           // read pointer
  logic [AW:0]   cnt_ff;          // words held
  logic          push;
  logic          pop;

  // pointer step with wrap
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o  = mem_ff[rp_ff];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // storage write
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data_i;
    end
  end

  // pointers and fill count
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wp_ff <= step(wp_ff);
      end
      if (pop) begin
        rp_ff <= step(rp_ff);
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + (AW+1)'(1);
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - (AW+1)'(1);
      end
    end
  end

endmodule

/* File: hdl/ps2s_status.sv */
`include "ps2s_params.svh"
module ps2s_status #(
  parameter int NCH       = `PS2S_NCH,
  parameter int FRAME_CYC = `PS2S_FRAME_CYC,
  parameter int START_CYC = `PS2S_START_CYC
) (
  // clock and reset
  input  wire logic                          sys_clk_i,
  input  wire logic                          reset_n_i,
  // processor register port
  input  wire logic [15:0]                   addr_i,
  input  wire logic                          rd_i,
  input  wire logic                          wr_i,
  input  wire logic [7:0]                    wdata_i,
  output logic      [7:0]                    rdata_o,
  // control bits and engine strobes
  input  ps2s_pkg::ps2s_ctrl_t [NCH-1:0]     ctrl_i,
  input  wire logic [NCH-1:0]                tx_write_i,
  input  wire logic [NCH-1:0]                rx_read_i,
  // channel pins
  input  wire logic [NCH-1:0]                ps2_clk_i,
  input  wire logic [NCH-1:0]                ps2_data_i,
  output logic      [NCH-1:0]                ps2_clk_o,
  output logic      [NCH-1:0]                ps2_clk_oe_o,
  output logic      [NCH-1:0]                ps2_data_o,
  output logic      [NCH-1:0]                ps2_data_oe_o,
  // direction hold and interrupts
  output logic      [NCH-1:0]                dir_hold_o,
  output logic      [NCH-1:0]                irq_o,
  // received byte stream
  output logic                               rx_valid_o,
  output ps2s_pkg::ps2s_rxword_t             rx_word_o,
  input  wire logic                          rx_ready_i
);

  localparam int LW = $clog2(START_CYC + 1);

  // ************************************************************
  // declarations
  // ************************************************************
  logic [NCH-1:0]          clk_m_ff;    // clock pin, first stage
  logic [NCH-1:0]          clk_s_ff;    // clock pin, synced
  logic [NCH-1:0]          clk_p_ff;    // synced clock, delayed
  logic [NCH-1:0]          dat_m_ff;    // data pin, first stage
  logic [NCH-1:0]          dat_s_ff;    // data pin, synced
  ps2s_pkg::ps2s_state_t   state_ff [NCH];
  logic [3:0]              edge_ff  [NCH];  // falling edges seen
  logic [11:0]             gap_ff   [NCH];  // since last edge / hold
  logic [LW-1:0]           long_ff  [NCH];  // frame or start wait
  logic [7:0]              sr_ff    [NCH];  // data bits
  logic [NCH-1:0]          acc_ff;      // running parity
  logic [NCH-1:0]          rdy_ff;      // receive ready
  logic [NCH-1:0]          rxe_ff;      // receive error
  logic [NCH-1:0]          pe_ff;       // parity error
  logic [NCH-1:0]          fe_ff;       // framing error
  logic [NCH-1:0]          txi_ff;      // transmit idle
  logic [NCH-1:0]          txto_ff;     // transmit timeout
  logic [NCH-1:0]          late_ff;     // start clock late
  logic [NCH-1:0]          seen_ff;     // status read in hold
  logic [NCH-1:0]          htx_ff;      // hold came from transmit
  logic [NCH-1:0]          pend_ff;     // byte waiting for buffer
  logic [7:0]              byte_ff  [NCH];
  logic [NCH-1:0]          rdy_q_ff;    // edge detect copies
  logic [NCH-1:0]          rxe_q_ff;
  logic [NCH-1:0]          txi_q_ff;
  // per-channel events
  logic [NCH-1:0] fall, gap_over, long_over, start_over, stat_rd;
  logic [NCH-1:0] rx_start, rx_err, rx_good, rx_drop, pe_ev, fe_ev;
  logic [NCH-1:0] tx_go, tx_late, tx_to, tx_done, tx_abort, hold_end;
  logic [NCH-1:0] en, dir;
  logic [7:0]     stat_w [NCH];
  logic [7:0]     stat2_w;
  // buffer fill side
  logic                     buf_valid;
  logic                     buf_ready;
  ps2s_pkg::ps2s_rxword_t   buf_word;
  logic [NCH-1:0]           buf_take;

  // status address of a channel
  function automatic logic [15:0] stat_addr(input int c);
    case (c)
      0:       stat_addr = `PS2S_ADDR_STAT_A;
      1:       stat_addr = `PS2S_ADDR_STAT_B;
      2:       stat_addr = `PS2S_ADDR_STAT_C;
      default: stat_addr = `PS2S_ADDR_STAT_D;
    endcase
  endfunction

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clk_m_ff <= '1;
      clk_s_ff <= '1;
      clk_p_ff <= '1;
      dat_m_ff <= '1;
      dat_s_ff <= '1;
    end else begin
      clk_m_ff <= ps2_clk_i;
      clk_s_ff <= clk_m_ff;
      clk_p_ff <= clk_s_ff;
      dat_m_ff <= ps2_data_i;
      dat_s_ff <= dat_m_ff;
    end
  end

  // ************************************************************
  // event decode
  // ************************************************************
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      en[c]         = ctrl_i[c].auto_engine_enable;
      dir[c]        = ctrl_i[c].direction_select;
      fall[c]       = clk_p_ff[c] & ~clk_s_ff[c];
      gap_over[c]   = (gap_ff[c] >= 12'(`PS2S_GAP_CYC));
      long_over[c]  = (32'(long_ff[c]) >= FRAME_CYC);
      start_over[c] = (32'(long_ff[c]) >= START_CYC);
      stat_rd[c]    = rd_i & (addr_i == stat_addr(c));
      // receive: parity on tenth edge
      pe_ev[c] = (state_ff[c] == ps2s_pkg::ST_RX) & en[c] & ~dir[c] & fall[c]
               & (edge_ff[c] == `PS2S_EDGE_PAR - 4'h1)
               & (ctrl_i[c].parity_mode != `PS2S_PAR_NONE)
               & ((acc_ff[c] ^ dat_s_ff[c])
                  != (ctrl_i[c].parity_mode == `PS2S_PAR_ODD));
      // receive: stop level on eleventh edge
      fe_ev[c] = (state_ff[c] == ps2s_pkg::ST_RX) & en[c] & ~dir[c] & fall[c]
               & (edge_ff[c] == `PS2S_EDGE_STOP - 4'h1)
               & (ctrl_i[c].stop_mode != `PS2S_STOP_NONE)
               & (dat_s_ff[c]
                  != (ctrl_i[c].stop_mode == `PS2S_STOP_HIGH));
      rx_err[c] = pe_ev[c] | fe_ev[c]
                | ((state_ff[c] == ps2s_pkg::ST_RX) & en[c] & (gap_over[c]
                   | (long_over[c] & (edge_ff[c] < `PS2S_EDGE_PAR))));
      rx_good[c] = (state_ff[c] == ps2s_pkg::ST_RX) & ~rx_err[c]
                 & ((en[c] & ~dir[c] & fall[c]
                     & (edge_ff[c] == `PS2S_EDGE_STOP - 4'h1))
                    | (~en[c] & (edge_ff[c] >= `PS2S_EDGE_PAR)));
      rx_drop[c] = (state_ff[c] == ps2s_pkg::ST_RX) & ~rx_err[c]
                 & ~rx_good[c] & (~en[c] | dir[c]);
      rx_start[c] = (state_ff[c] == ps2s_pkg::ST_IDLE) & en[c] & ~dir[c]
                  & fall[c] & ~rdy_ff[c] & ~pend_ff[c];
      // transmit
      tx_go[c] = (state_ff[c] == ps2s_pkg::ST_IDLE) & en[c] & dir[c]
               & tx_write_i[c] & ~rdy_ff[c] & ~pend_ff[c];
      tx_late[c] = (state_ff[c] == ps2s_pkg::ST_TXW) & en[c] & dir[c]
                 & start_over[c];
      tx_to[c] = tx_late[c]
               | ((state_ff[c] == ps2s_pkg::ST_TX) & en[c] & dir[c]
                  & (gap_over[c]
                     | (long_over[c] & (edge_ff[c] < `PS2S_EDGE_PAR))));
      tx_done[c] = (state_ff[c] == ps2s_pkg::ST_TX) & fall[c]
                 & (edge_ff[c] == `PS2S_EDGE_STOP - 4'h1);
      tx_abort[c] = ((state_ff[c] == ps2s_pkg::ST_TXW)
                     | (state_ff[c] == ps2s_pkg::ST_TX)) & ~(en[c] & dir[c]);
      hold_end[c] = (state_ff[c] == ps2s_pkg::ST_HOLD) & gap_over[c]
                  & (seen_ff[c] | stat_rd[c]);
    end
  end

  // ************************************************************
  // frame engine and interval counters
  // ************************************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int c = 0; c < NCH; c++) begin
        state_ff[c] <= ps2s_pkg::ST_IDLE;
        edge_ff[c]  <= 4'h0;
        gap_ff[c]   <= 12'h000;
        long_ff[c]  <= '0;
        sr_ff[c]    <= 8'h00;
      end
      acc_ff <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        // counters free-run, saturating
        if (!gap_over[c]) begin
          gap_ff[c] <= gap_ff[c] + 12'h001;
        end
        if (!start_over[c]) begin
          long_ff[c] <= long_ff[c] + LW'(1);
        end
        case (state_ff[c])
          ps2s_pkg::ST_IDLE: begin
            if (rx_start[c]) begin
              state_ff[c] <= ps2s_pkg::ST_RX;
              edge_ff[c]  <= 4'h1;
              gap_ff[c]   <= 12'h000;
              long_ff[c]  <= '0;
              acc_ff[c]   <= 1'b0;
            end else if (tx_go[c]) begin
              state_ff[c] <= ps2s_pkg::ST_TXW;
              long_ff[c]  <= '0;
            end
          end
          ps2s_pkg::ST_RX: begin
            if (rx_err[c]) begin
              state_ff[c] <= ps2s_pkg::ST_HOLD;
              gap_ff[c]   <= 12'h000;
            end else if (rx_good[c] || rx_drop[c]) begin
              state_ff[c] <= ps2s_pkg::ST_IDLE;
            end else if (fall[c]) begin
              edge_ff[c] <= edge_ff[c] + 4'h1;
              gap_ff[c]  <= 12'h000;
              // data bits arrive on edges two to nine
              if (edge_ff[c] >= 4'h1 && edge_ff[c] <= 4'h8) begin
                sr_ff[c]  <= {dat_s_ff[c], sr_ff[c][7:1]};
                acc_ff[c] <= acc_ff[c] ^ dat_s_ff[c];
              end
            end
          end
          ps2s_pkg::ST_TXW: begin
            if (tx_abort[c]) begin
              state_ff[c] <= ps2s_pkg::ST_IDLE;
            end else if (tx_to[c]) begin
              state_ff[c] <= ps2s_pkg::ST_HOLD;
              gap_ff[c]   <= 12'h000;
            end else if (fall[c]) begin
              state_ff[c] <= ps2s_pkg::ST_TX;
              edge_ff[c]  <= 4'h1;
              gap_ff[c]   <= 12'h000;
              long_ff[c]  <= '0;
            end
          end
          ps2s_pkg::ST_TX: begin
            if (tx_abort[c] || tx_done[c]) begin
              state_ff[c] <= ps2s_pkg::ST_IDLE;
            end else if (tx_to[c]) begin
              state_ff[c] <= ps2s_pkg::ST_HOLD;
              gap_ff[c]   <= 12'h000;
            end else if (fall[c]) begin
              edge_ff[c] <= edge_ff[c] + 4'h1;
              gap_ff[c]  <= 12'h000;
            end
          end
          ps2s_pkg::ST_HOLD: begin
            if (hold_end[c]) begin
              state_ff[c] <= ps2s_pkg::ST_IDLE;
            end
          end
          default: begin
            state_ff[c] <= ps2s_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // status flags, set wins over clear except seen_ff, where the clear wins
  // ************************************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdy_ff  <= '0;
      rxe_ff  <= '0;
      pe_ff   <= '0;
      fe_ff   <= '0;
      txi_ff  <= '0;
      txto_ff <= '0;
      late_ff <= '0;
      seen_ff <= '0;
      htx_ff  <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        // clears from reads and writes
        if (rx_read_i[c]) rdy_ff[c] <= 1'b0;
        if (stat_rd[c]) begin
          rxe_ff[c]  <= 1'b0;
          pe_ff[c]   <= 1'b0;
          fe_ff[c]   <= 1'b0;
          txto_ff[c] <= 1'b0;
          seen_ff[c] <= 1'b1;
        end
        if (wr_i && addr_i == `PS2S_ADDR_STAT2 && wdata_i[2*c+1]) begin
          late_ff[c] <= 1'b0;
        end
        if (tx_go[c]) txi_ff[c] <= 1'b0;
        if (hold_end[c]) htx_ff[c] <= 1'b0;
        // sets
        if (rx_good[c]) rdy_ff[c] <= 1'b1;
        if (rx_err[c]) rxe_ff[c] <= 1'b1;
        if (pe_ev[c]) pe_ff[c] <= 1'b1;
        if (fe_ev[c]) fe_ff[c] <= 1'b1;
        if (tx_to[c]) begin
          txto_ff[c] <= 1'b1;
          htx_ff[c]  <= 1'b1;
        end
        if (tx_late[c]) late_ff[c] <= 1'b1;
        if (rx_err[c] || tx_to[c]) seen_ff[c] <= 1'b0;
        // idle returns on end, timeout, or engine off or set to receive
        if (tx_done[c] || tx_to[c] || tx_abort[c]
            || (state_ff[c] == ps2s_pkg::ST_IDLE && !(en[c] && dir[c]))) begin
          txi_ff[c] <= 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // received bytes into the shared buffer
  // ************************************************************
  always_comb begin
    buf_take = '0;
    buf_word = '0;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (pend_ff[c]) begin
        buf_take      = '0;
        buf_take[c]   = buf_ready;
        buf_word.chan = 2'(c);
        buf_word.data = byte_ff[c];
      end
    end
    buf_valid = |pend_ff;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pend_ff <= '0;
      for (int c = 0; c < NCH; c++) begin
        byte_ff[c] <= 8'h00;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (buf_take[c]) pend_ff[c] <= 1'b0;
        if (rx_good[c]) begin
          pend_ff[c] <= 1'b1;
          byte_ff[c] <= sr_ff[c];
        end
      end
    end
  end

  ps2s_buf2 #(
    .W     (10),
    .DEPTH (2)
  ) u_buf (
    .sys_clk_i   (sys_clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (buf_valid),
    .in_data_i   (buf_word),
    .in_ready_o  (buf_ready),
    .out_valid_o (rx_valid_o),
    .out_data_o  (rx_word_o),
    .out_ready_i (rx_ready_i)
  );

  // ************************************************************
  // pin drive: hold-off, ready inhibit, bit-bang
  // ************************************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ps2_clk_o     <= '0;
      ps2_data_o    <= '0;
      ps2_clk_oe_o  <= '0;
      ps2_data_oe_o <= '0;
      dir_hold_o    <= '0;
    end else begin
      ps2_clk_o  <= '0;
      ps2_data_o <= '0;
      for (int c = 0; c < NCH; c++) begin
        ps2_clk_oe_o[c] <= (state_ff[c] == ps2s_pkg::ST_HOLD)
                         | (en[c] & (rdy_ff[c] | pend_ff[c]))
                         | (~en[c] & ~ctrl_i[c].wr_clk
                            & ~rdy_ff[c] & (state_ff[c] != ps2s_pkg::ST_HOLD));
        ps2_data_oe_o[c] <= ~en[c] & ~ctrl_i[c].wr_data
                          & ~rdy_ff[c] & (state_ff[c] != ps2s_pkg::ST_HOLD);
        dir_hold_o[c] <= htx_ff[c] | tx_to[c];
      end
    end
  end

  // ************************************************************
  // interrupts on rising ready, receive error and transmit idle flags and bit-bang clock falls
  // ************************************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdy_q_ff <= '0;
      rxe_q_ff <= '0;
      txi_q_ff <= '0;
      irq_o    <= '0;
    end else begin
      rdy_q_ff <= rdy_ff;
      rxe_q_ff <= rxe_ff;
      txi_q_ff <= txi_ff;
      irq_o <= (rdy_ff & ~rdy_q_ff) | (rxe_ff & ~rxe_q_ff)
             | (txi_ff & ~txi_q_ff)
             | (~en & fall & ~ps2_clk_oe_o);
    end
  end

  // ************************************************************
  // status register images and read port
  // ************************************************************
  always_comb begin
    stat2_w = `PS2S_STAT2_RST;
    for (int c = 0; c < NCH; c++) begin
      stat_w[c]                = `PS2S_STAT_RST;
      stat_w[c][`PS2S_B_RDY]   = rdy_ff[c];
      stat_w[c][`PS2S_B_RXE]   = rxe_ff[c];
      stat_w[c][`PS2S_B_PE]    = pe_ff[c];
      stat_w[c][`PS2S_B_FE]    = fe_ff[c];
      stat_w[c][`PS2S_B_TXI]   = txi_ff[c];
      stat_w[c][`PS2S_B_TXTO]  = txto_ff[c];
      stat_w[c][`PS2S_B_DAT]   = dat_s_ff[c];
      stat_w[c][`PS2S_B_CLK]   = clk_s_ff[c];
      stat2_w[2*c]             = (state_ff[c] == ps2s_pkg::ST_RX);
      stat2_w[2*c+1]           = late_ff[c];
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= `PS2S_RDATA_RST;
    end else if (rd_i) begin
      rdata_o <= 8'h00;  // unmapped reads give zero
      if (addr_i == `PS2S_ADDR_STAT2) begin
        rdata_o <= stat2_w;
      end
      for (int c = 0; c < NCH; c++) begin
        if (stat_rd[c]) rdata_o <= stat_w[c];
      end
    end
  end

endmodule

/* File: tb/ps2s_status_assertions.sv */
// *****
// port checks
// *****
module ps2s_status_assertions #(
  parameter int NCH = 4
) (
  input wire logic              sys_clk_i,
  input wire logic              reset_n_i,
  input wire logic [15:0]       addr_i,
  input wire logic              rd_i,
  input wire logic [7:0]        rdata_o,
  input wire logic [NCH-1:0]    ps2_clk_o,
  input wire logic [NCH-1:0]    ps2_clk_oe_o,
  input wire logic [NCH-1:0]    ps2_data_o,
  input wire logic [NCH-1:0]    dir_hold_o,
  input wire logic [NCH-1:0]    irq_o,
  input wire logic              rx_valid_o,
  input ps2s_pkg::ps2s_rxword_t rx_word_o,
  input wire logic              rx_ready_i
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  a_unmapped_zero: assert property (rd_i && !(addr_i inside {16'h7F43, 16'h7F47,
    16'h7F48, 16'h7F4B, 16'h7F4F}) |=> rdata_o == 8'h00) else $error("bad unmapped read");
  a_rdata_holds: assert property (!rd_i |=> $stable(rdata_o)) else $error("rdata moved");
  a_irq_single: assert property (irq_o[0] |=> !irq_o[0]) else $error("irq too long");
  a_ready_irq: assert property ($rose(rx_valid_o) |-> irq_o != '0) else $error("no irq");
  a_clk_out_low: assert property (ps2_clk_o == '0) else $error("clk level");
  a_data_out_low: assert property (ps2_data_o == '0) else $error("data level");
  a_stream_holds: assert property (rx_valid_o && !rx_ready_i
    |=> rx_valid_o && $stable(rx_word_o)) else $error("word lost");
  a_hold_pulls_clk: assert property ($rose(dir_hold_o[0])
    |-> ##[0:2] ps2_clk_oe_o[0]) else $error("clk not held");
  cover property (rx_valid_o && !rx_ready_i);
  cover property ($rose(dir_hold_o[0]));
  cover property (irq_o[0]);
endmodule
bind ps2s_status ps2s_status_assertions #(.NCH(NCH)) u_chk (.sys_clk_i, .reset_n_i,
  .addr_i, .rd_i, .rdata_o, .ps2_clk_o, .ps2_clk_oe_o, .ps2_data_o, .dir_hold_o,
  .irq_o, .rx_valid_o, .rx_word_o, .rx_ready_i);

/* File: tb/ps2s_dev_model.sv */
// *****
// peripheral on channel a
// *****
module ps2s_dev_model (
  input  wire logic line_clk_i,
  output logic      clk_o = 1,
  output logic      data_o = 1
);
  timeunit 1ns;
  timeprecision 1ns;
  // start, data lsb first, parity, stop; n falls
  task send(input logic [7:0] b, input logic par, stp, input int n);
    logic [10:0] f;
    f = {stp, par, b, 1'b0};
    wait (line_clk_i);
    for (int i = 0; i < n; i++) begin
      data_o = f[i];
      #200 clk_o = 0;
      #400 clk_o = 1;
      #200;
    end
    data_o = 1;
  endtask
endmodule

/* File: tb/ps2s_status_tb.sv */
// *****
// bench top
// *****
module ps2s_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                       sys_clk_i = 0, reset_n_i = 0, rd_i = 0, wr_i = 0, rd_d = 0;
  logic                       rx_ready_i = 1, m_clk, m_data, rx_valid_o;
  logic [15:0]                addr_i = '0;
  logic [7:0]                 wdata_i = '0, rdata_o, b;
  logic [3:0]                 tx_write_i = '0, rx_read_i = '0, c_oe, d_oe;
  ps2s_pkg::ps2s_ctrl_t [3:0] ctrl_i = {4{8'hC2}};
  ps2s_pkg::ps2s_rxword_t     rx_word_o;
  logic [9:0]                 rq[$], wq[$];
  int                         mismatches = 0, tests_run = 0, cyc = 0;
  wire  [3:0]                 pin_c = {3'h7, m_clk} & ~c_oe;
  wire  [3:0]                 pin_d = {3'h7, m_data} & ~d_oe;
  ps2s_status #(.FRAME_CYC(200), .START_CYC(2000)) u_ps2s_status (.sys_clk_i, .reset_n_i,
    .addr_i, .rd_i, .wr_i, .wdata_i, .rdata_o, .ctrl_i, .tx_write_i, .rx_read_i,
    .ps2_clk_i(pin_c), .ps2_data_i(pin_d), .ps2_clk_o(), .ps2_clk_oe_o(c_oe),
    .ps2_data_o(), .ps2_data_oe_o(d_oe), .dir_hold_o(), .irq_o(), .rx_valid_o,
    .rx_word_o, .rx_ready_i);
  ps2s_dev_model u_ps2s_dev_model (.line_clk_i(pin_c[0]), .clk_o(m_clk), .data_o(m_data));
  always #50 sys_clk_i = ~sys_clk_i;
  task close_out;
    $display("counts: run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [9:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task w(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    w(1);
    addr_i = a;
    rd_i = 1;
    rq.push_back({2'h0, e});
    w(1);
    rd_i = 0;
  endtask
  // watcher: oldest note against each result
  always @(posedge sys_clk_i) begin
    if (rd_d) chk({2'h0, rdata_o}, rq.pop_front());
    if (rx_valid_o && rx_ready_i) chk(rx_word_o, wq.pop_front());
    rd_d <= rd_i;
    if (++cyc == 40000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    void'($urandom(12209));
    w(12);
    reset_n_i = 1;
    rd(16'h7F43, 8'hD0);
    rd(16'h7F48, 8'h00);
    rd(16'h7F40, 8'h00);
    $display("reset values done");
    rx_ready_i = 0;
    for (int p = 0; p < 3; p++) begin
      b = 8'($urandom);
      ctrl_i[0].parity_mode = 2'(p);
      wq.push_back({2'h0, b});
      u_ps2s_dev_model.send(b, ~^b ^ (p == 1), 1'b1, 11);
      w(10);
      rd(16'h7F43, 8'h51);
      rx_read_i[0] = 1;
      w(1);
      rx_read_i[0] = 0;
    end
    rx_ready_i = 1;
    ctrl_i[0].parity_mode = 2'h0;
    $display("stalled frames done");
    // k=2 stops after parity (bit gap), k=3 stops early (frame time)
    for (int k = 0; k < 4; k++) begin
      b = 8'($urandom);
      u_ps2s_dev_model.send(b, ~^b ^ (k == 0), k != 1, k == 2 ? 10 : k == 3 ? 5 : 11);
      w(k >= 2 ? 3100 : 10);
      rd(16'h7F43, k == 0 ? 8'h56 : k == 1 ? 8'h5A : 8'h52);
      rd(16'h7F43, 8'h50);
      w(3100);
    end
    $display("receive errors done");
    rd(16'h7F48, 8'h00);
    ctrl_i[0].direction_select = 1;
    tx_write_i[0] = 1;
    w(1);
    tx_write_i[0] = 0;
    w(2100);
    rd(16'h7F43, 8'h70);
    rd(16'h7F48, 8'h02);
    addr_i = 16'h7F48;
    wdata_i = 8'h02;
    wr_i = 1;
    w(1);
    wr_i = 0;
    rd(16'h7F48, 8'h00);
    w(2);
    $display("transmit timeout done");
    close_out();
  end
endmodule
